// File: hdl/sfr_params.svh
// constants for the operand side-effect datapath: file map, status bits, reset values
// assumes it is included by the package, the core and the bench, never on its own
`ifndef SFR_PARAMS_SVH
`define SFR_PARAMS_SVH

// ----------------------------------------------------------------
// file register map
// ----------------------------------------------------------------
`define SFR_A_PCL 7'h02
`define SFR_A_STATUS 7'h03
`define SFR_A_PORT 7'h05
`define SFR_A_PINDIR 7'h06
`define SFR_A_HOLD 7'h0a
`define SFR_GP_BASE 7'h20

// ----------------------------------------------------------------
// status and direction bit positions
// ----------------------------------------------------------------
`define SFR_C_BIT 0
`define SFR_DC_BIT 1
`define SFR_Z_BIT 2
`define SFR_INPIN_BIT 3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SFR_RST_STATUS 8'h00
`define SFR_RST_PINDIR 8'hff
`define SFR_RST_PORT 8'h00
`define SFR_RST_HOLD 8'h00
`define SFR_RST_W 8'h00

`endif

// File: hdl/sfr_pkg.sv
// types shared by the core, its alu and the carrier between them
// assumes sfr_params.svh is on the include path
`include "sfr_params.svh"

package sfr_pkg;

   // ----------------------------------------------------------------
   // instruction kinds handled by the datapath
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_ADDWF, OP_ANDWF, OP_CLRF, OP_CLRW, OP_COMF, OP_DECF, OP_INCF,
      OP_IORWF, OP_MOVF, OP_MOVWF, OP_SUBWF, OP_SWAPF, OP_XORWF,
      OP_RLF, OP_RRF, OP_BCF, OP_BSF
   } alu_op_t;

   // which status flags an instruction produces
   typedef struct packed {
      logic z;
      logic dc;
      logic c;
   } flag_sel_t;

endpackage : sfr_pkg

// File: hdl/alu_if.sv
// carrier between the operand core and its alu
// assumes sfr_pkg is compiled first
`timescale 1ns/1ps

interface alu_if;
   import sfr_pkg::*;
   logic [7:0] a;
   logic [7:0] w;
   alu_op_t op;
   logic [2:0] bsel;
   logic cin;
   logic [7:0] res;
   logic c;
   logic dc;
   logic z;
   flag_sel_t aff;

   modport core (output a, w, op, bsel, cin, input res, c, dc, z, aff);
   modport unit (input a, w, op, bsel, cin, output res, c, dc, z, aff);
endinterface : alu_if

// File: hdl/sfr_alu.sv
// purely combinational 8-bit alu with flag results and flag-affect mask
// assumes operands are stable within the cycle it is used
`timescale 1ns/1ps

module sfr_alu
   import sfr_pkg::*;
(
   // operand and result carrier
   alu_if.unit u
);

   logic [8:0] sum9;
   logic [4:0] sum5;

   always_comb begin
      sum9 = 9'h000;
      sum5 = 5'h00;
      u.res = u.a;
      u.c = 1'b0;
      u.dc = 1'b0;
      u.aff = '{z: 1'b0, dc: 1'b0, c: 1'b0};
      case (u.op)
         OP_ADDWF: begin
            sum9 = {1'b0, u.a} + {1'b0, u.w};
            sum5 = {1'b0, u.a[3:0]} + {1'b0, u.w[3:0]};
            u.res = sum9[7:0];
            u.c = sum9[8];
            u.dc = sum5[4];
            u.aff = '{z: 1'b1, dc: 1'b1, c: 1'b1};
         end
         OP_SUBWF: begin
            // carry and nibble carry mean "no borrow"
            sum9 = {1'b0, u.a} + {1'b0, ~u.w} + 9'h001;
            sum5 = {1'b0, u.a[3:0]} + {1'b0, ~u.w[3:0]} + 5'h01;
            u.res = sum9[7:0];
            u.c = sum9[8];
            u.dc = sum5[4];
            u.aff = '{z: 1'b1, dc: 1'b1, c: 1'b1};
         end
         OP_ANDWF: begin
            u.res = u.a & u.w;
            u.aff.z = 1'b1;
         end
         OP_IORWF: begin
            u.res = u.a | u.w;
            u.aff.z = 1'b1;
         end
         OP_XORWF: begin
            u.res = u.a ^ u.w;
            u.aff.z = 1'b1;
         end
         OP_CLRF, OP_CLRW: begin
            u.res = 8'h00;
            u.aff.z = 1'b1;
         end
         OP_COMF: begin
            u.res = ~u.a;
            u.aff.z = 1'b1;
         end
         OP_DECF: begin
            u.res = u.a - 8'h01;
            u.aff.z = 1'b1;
         end
         OP_INCF: begin
            u.res = u.a + 8'h01;
            u.aff.z = 1'b1;
         end
         OP_MOVF: begin
            u.res = u.a;
            u.aff.z = 1'b1;
         end
         OP_MOVWF: u.res = u.w;
         OP_SWAPF: u.res = {u.a[3:0], u.a[7:4]};
         OP_RLF: begin
            u.res = {u.a[6:0], u.cin};
            u.c = u.a[7];
            u.aff.c = 1'b1;
         end
         OP_RRF: begin
            u.res = {u.cin, u.a[7:1]};
            u.c = u.a[0];
            u.aff.c = 1'b1;
         end
         // whole byte in, one bit changed, whole byte out
         OP_BCF: u.res = u.a & ~(8'h01 << u.bsel);
         OP_BSF: u.res = u.a | (8'h01 << u.bsel);
         default: u.res = u.a;
      endcase
      u.z = (u.res == 8'h00);
   end

endmodule : sfr_alu

// File: hdl/sfr_operand_side_effects.sv
// datapath core: file registers, special registers and their side effects
// assumes ex_* and reg_* come from logic on clk_i; pin_in_i is asynchronous
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "sfr_params.svh"

// Functional notes
// - all file registers readable and writable operands
// - produced flags override bytes written to status
// - direction register bit 3 always reads one
// - reading low pc byte gives current count
// - low pc write also loads high from holding
// - high pc byte unaddressable, loaded from holding
// - bit ops rewrite whole byte, one bit changed
// - destination bit zero accumulator, one file; movwf, clrf, bcf, bsf always file, clrw always accumulator
module sfr_operand_side_effects
   import sfr_pkg::*;
#(
   parameter int GP_DEPTH = 32,
   parameter int PCH_W = 5
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // instruction execute port
   input wire logic ex_valid_i,
   input wire alu_op_t ex_op_i,
   input wire logic [6:0] ex_faddr_i,
   input wire logic ex_dest_i,
   input wire logic [2:0] ex_bit_i,
   // software register port
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_we_i,
   input wire logic reg_re_i,
   output logic [7:0] reg_rdata_o,
   // port pins
   input wire logic [7:0] pin_in_i,
   output logic [7:0] port_out_o,
   output logic [7:0] port_oe_n_o,
   // visible state
   output logic [7:0] w_o,
   output logic [7:0] status_o,
   output logic [8+PCH_W-1:0] pc_o,
   output logic ex_done_o
);

   localparam int GW = (GP_DEPTH > 1) ? $clog2(GP_DEPTH) : 1;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (GP_DEPTH < 1 || GP_DEPTH > 96 || PCH_W < 1 || PCH_W > 8) begin : g_bad_param
      $error("GP_DEPTH must lie in 1 to 96 and PCH_W in 1 to 8");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] w_r;
   logic [7:0] status_r;
   logic [7:0] status_nxt;
   logic [7:0] pindir_r;
   logic [7:0] port_r;
   logic [7:0] hold_r;
   logic [7:0] pc_low_r;
   logic [PCH_W-1:0] pc_high_r;
   logic [8+PCH_W-1:0] pc_nxt;
   logic [7:0] gp_ram_r [GP_DEPTH];
   logic [7:0] pin_meta_r;
   logic [7:0] pin_sync_r;
   logic [7:0] rdata_r;
   logic done_r;

   // ----------------------------------------------------------------
   // file read decode
   // ----------------------------------------------------------------
   function automatic logic gp_hit(input logic [6:0] a);
      logic [7:0] off;
      off = {1'b0, a} - {1'b0, `SFR_GP_BASE};
      gp_hit = (a >= `SFR_GP_BASE) && (off < 8'(GP_DEPTH));
   endfunction : gp_hit
   function automatic logic [GW-1:0] gp_idx(input logic [6:0] a);
      logic [6:0] off;
      off = a - `SFR_GP_BASE;
      gp_idx = off[GW-1:0];
   endfunction : gp_idx

   // the high pc byte has no address and reads as zero like any hole
   function automatic logic [7:0] file_rd(input logic [6:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `SFR_A_PCL: v = pc_low_r;
         `SFR_A_STATUS: v = status_r;
         `SFR_A_PORT: v = pin_sync_r;
         `SFR_A_PINDIR: v = pindir_r;
         `SFR_A_HOLD: v = hold_r;
         default: v = gp_hit(a) ? gp_ram_r[gp_idx(a)] : 8'h00;
      endcase
      file_rd = v;
   endfunction : file_rd

   // ----------------------------------------------------------------
   // alu and write steering
   // ----------------------------------------------------------------
   alu_if alu ();
   sfr_alu u_alu (
      .u(alu)
   );

   logic [7:0] operand;
   logic ex_to_file;
   logic wr_en;
   logic [6:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_pcl;

   // port reads see the pins, so a bit op on the port may copy pin levels
   always_comb operand = file_rd(ex_faddr_i);
   assign alu.a = operand;
   assign alu.w = w_r;
   assign alu.op = ex_op_i;
   assign alu.bsel = ex_bit_i;
   assign alu.cin = status_r[`SFR_C_BIT];

   always_comb begin
      case (ex_op_i)
         OP_MOVWF, OP_CLRF, OP_BCF, OP_BSF: ex_to_file = 1'b1;
         OP_CLRW: ex_to_file = 1'b0;
         default: ex_to_file = ex_dest_i;
      endcase
   end

   // an instruction owns the write path; a software write in that cycle is dropped
   assign wr_en = ex_valid_i ? ex_to_file : reg_we_i;
   assign wr_addr = ex_valid_i ? ex_faddr_i : reg_addr_i;
   assign wr_data = ex_valid_i ? alu.res : reg_wdata_i;
   assign wr_pcl = wr_en && (wr_addr == `SFR_A_PCL);

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_r <= 8'h00;
         pin_sync_r <= 8'h00;
      end else begin
         pin_meta_r <= pin_in_i;
         pin_sync_r <= pin_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // accumulator
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         w_r <= `SFR_RST_W;
      end else if (ex_valid_i && !ex_to_file) begin
         w_r <= alu.res;
      end
   end

   // ----------------------------------------------------------------
   // status: written byte first, produced flags on top
   // ----------------------------------------------------------------
   always_comb begin
      status_nxt = status_r;
      if (wr_en && wr_addr == `SFR_A_STATUS) begin
         status_nxt = wr_data;
      end
      if (ex_valid_i) begin
         if (alu.aff.z) begin
            status_nxt[`SFR_Z_BIT] = alu.z;
         end
         if (alu.aff.dc) begin
            status_nxt[`SFR_DC_BIT] = alu.dc;
         end
         if (alu.aff.c) begin
            status_nxt[`SFR_C_BIT] = alu.c;
         end
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_r <= `SFR_RST_STATUS;
      end else begin
         status_r <= status_nxt;
      end
   end

   // ----------------------------------------------------------------
   // port latch, direction and holding registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pindir_r <= `SFR_RST_PINDIR;
      end else if (wr_en && wr_addr == `SFR_A_PINDIR) begin
         pindir_r <= wr_data | (8'h01 << `SFR_INPIN_BIT);
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_r <= `SFR_RST_PORT;
      end else if (wr_en && wr_addr == `SFR_A_PORT) begin
         port_r <= wr_data;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hold_r <= `SFR_RST_HOLD;
      end else if (wr_en && wr_addr == `SFR_A_HOLD) begin
         hold_r <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // program counter
   // ----------------------------------------------------------------
   always_comb begin
      if (wr_pcl) begin
         pc_nxt = {hold_r[PCH_W-1:0], wr_data};
      end else if (ex_valid_i) begin
         pc_nxt = {pc_high_r, pc_low_r} + (8+PCH_W)'(1);
      end else begin
         pc_nxt = {pc_high_r, pc_low_r};
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pc_low_r <= 8'h00;
         pc_high_r <= '0;
      end else begin
         pc_low_r <= pc_nxt[7:0];
         pc_high_r <= pc_nxt[8+PCH_W-1:8];
      end
   end

   // ----------------------------------------------------------------
   // general purpose file
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < GP_DEPTH; i++) begin
            gp_ram_r[i] <= 8'h00;
         end
      end else if (wr_en && gp_hit(wr_addr)) begin
         gp_ram_r[gp_idx(wr_addr)] <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // software read data and done pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else if (reg_re_i) begin
         rdata_r <= file_rd(reg_addr_i);
      end else begin
         rdata_r <= 8'h00;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         done_r <= 1'b0;
      end else begin
         done_r <= ex_valid_i;
      end
   end

   assign reg_rdata_o = rdata_r;
   assign port_out_o = port_r;
   assign port_oe_n_o = pindir_r;
   assign w_o = w_r;
   assign status_o = status_r;
   assign pc_o = {pc_high_r, pc_low_r};
   assign ex_done_o = done_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_dest_w;
      @(posedge clk_i) disable iff (rst_i)
      (ex_valid_i && !ex_to_file) |=> (w_o == $past(alu.res));
   endproperty
   a_dest_w: assert property (p_dest_w) else $error("result missed accumulator");
   property p_flag_override;
      @(posedge clk_i) disable iff (rst_i)
      (ex_valid_i && ex_to_file && ex_faddr_i == `SFR_A_STATUS && alu.aff.z)
      |=> (status_o[`SFR_Z_BIT] == $past(alu.z)) && ex_done_o;
   endproperty
   a_flag_override: assert property (p_flag_override) else $error("zero flag not produced");
   property p_pindir_bit3;
      @(posedge clk_i) disable iff (rst_i)
      (reg_re_i && reg_addr_i == `SFR_A_PINDIR) |=> reg_rdata_o[`SFR_INPIN_BIT];
   endproperty
   a_pindir_bit3: assert property (p_pindir_bit3) else $error("direction bit 3 read zero");
   property p_read_pcl;
      @(posedge clk_i) disable iff (rst_i)
      (reg_re_i && reg_addr_i == `SFR_A_PCL) |=> (reg_rdata_o == $past(pc_low_r));
   endproperty
   a_read_pcl: assert property (p_read_pcl) else $error("low pc read wrong");
   property p_write_pcl;
      @(posedge clk_i) disable iff (rst_i)
      wr_pcl |=> (pc_o == {$past(hold_r[PCH_W-1:0]), $past(wr_data)});
   endproperty
   a_write_pcl: assert property (p_write_pcl) else $error("low pc write lost holding");
   property p_rmw_pcl;
      @(posedge clk_i) disable iff (rst_i)
      (ex_valid_i && ex_to_file && ex_faddr_i == `SFR_A_PCL && ex_op_i == OP_INCF)
      |=> (pc_o == {$past(hold_r[PCH_W-1:0]), $past(pc_low_r) + 8'h01});
   endproperty
   a_rmw_pcl: assert property (p_rmw_pcl) else $error("low pc modify wrong");
   property p_high_only_hold;
      @(posedge clk_i) disable iff (rst_i)
      (!wr_pcl && !(ex_valid_i && pc_low_r == 8'hff)) |=> $stable(pc_high_r);
   endproperty
   a_high_only_hold: assert property (p_high_only_hold) else $error("high pc changed");
   property p_bit_op;
      @(posedge clk_i) disable iff (rst_i)
      (ex_valid_i && (ex_op_i == OP_BCF || ex_op_i == OP_BSF))
      |-> (((alu.res ^ operand) & ~(8'h01 << ex_bit_i)) == 8'h00)
          && (alu.res[ex_bit_i] == (ex_op_i == OP_BSF));
   endproperty
   a_bit_op: assert property (p_bit_op) else $error("bit op touched other bits");
   property p_sw_status;
      @(posedge clk_i) disable iff (rst_i)
      (!ex_valid_i && reg_we_i && reg_addr_i == `SFR_A_STATUS)
      ##1 (!ex_valid_i && reg_re_i && reg_addr_i == `SFR_A_STATUS)
      |=> (reg_rdata_o == $past(reg_wdata_i, 2));
   endproperty
   a_sw_status: assert property (p_sw_status) else $error("status write not read back");

endmodule : sfr_operand_side_effects

// File: tb/sfr_operand_side_effects_test.sv
// self-checking bench for the operand side-effect datapath
// assumes sfr_pkg, alu_if, sfr_alu and the core are compiled first
`timescale 1ns/1ps
`include "sfr_params.svh"

module sfr_operand_side_effects_test
   import sfr_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ex_valid = 1'b0;
   alu_op_t ex_op = OP_MOVF;
   logic [6:0] ex_faddr = 7'h00;
   logic ex_dest = 1'b0;
   logic [2:0] ex_bit = 3'h0;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic [7:0] pin_in = 8'h3c;
   logic [7:0] reg_rdata;
   logic [7:0] port_out;
   logic [7:0] port_oe_n;
   logic [7:0] w;
   logic [7:0] status;
   logic [12:0] pc;
   logic ex_done;
   logic [12:0] pc_m = 13'h0000;
   logic [7:0] hold_m = 8'h00;
   logic [7:0] v;
   int error_cnt = 0;
   int num_checks = 0;

   sfr_operand_side_effects #(.GP_DEPTH(32), .PCH_W(5)) dut (
      .clk_i(clk_i), .rst_i(rst_i),
      .ex_valid_i(ex_valid), .ex_op_i(ex_op), .ex_faddr_i(ex_faddr),
      .ex_dest_i(ex_dest), .ex_bit_i(ex_bit),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
      .reg_re_i(reg_re), .reg_rdata_o(reg_rdata),
      .pin_in_i(pin_in), .port_out_o(port_out), .port_oe_n_o(port_oe_n),
      .w_o(w), .status_o(status), .pc_o(pc), .ex_done_o(ex_done)
   );

   initial begin
      forever #5 clk_i = ~clk_i;
   end

   // ----------------------------------------------------------------
   // compare, report and bus tasks
   // ----------------------------------------------------------------
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_byte

   task automatic chk_pc(input logic [12:0] e);
      num_checks++;
      if (pc !== e) begin
         error_cnt++;
         $display("FAIL pc expected %h seen %h", e, pc);
      end
   endtask : chk_pc

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_i);
      reg_we <= 1'b0;
      #1;
      if (a == `SFR_A_HOLD) hold_m = d;
      if (a == `SFR_A_PCL) pc_m = {hold_m[4:0], d};
   endtask : wr

   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_re <= 1'b1;
      reg_addr <= a;
      @(posedge clk_i);
      reg_re <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   // one instruction; the model pc steps by one, callers override pcl writes
   task automatic exec(input alu_op_t op, input logic [6:0] fa, input logic d,
                       input logic [2:0] b);
      int i;
      @(posedge clk_i);
      ex_valid <= 1'b1;
      ex_op <= op;
      ex_faddr <= fa;
      ex_dest <= d;
      ex_bit <= b;
      @(posedge clk_i);
      ex_valid <= 1'b0;
      #1;
      i = 0;
      while (ex_done !== 1'b1 && i < 4) begin
         @(posedge clk_i);
         #1;
         i++;
      end
      if (ex_done !== 1'b1) begin
         error_cnt++;
         $display("FAIL ex_done expected 1 seen %b", ex_done);
         finish_test();
      end
      pc_m = pc_m + 13'h0001;
   endtask : exec

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk_byte("status", 8'h00, status);
      chk_byte("w", 8'h00, w);
      chk_byte("oe_n", 8'hff, port_oe_n);
      chk_pc(13'h0000);
   endtask : t_reset

   task automatic t_status();
      wr(`SFR_GP_BASE, 8'h1f);
      exec(OP_MOVF, `SFR_GP_BASE, 1'b0, 3'h0);
      chk_byte("w", 8'h1f, w);
      exec(OP_MOVWF, `SFR_A_STATUS, 1'b1, 3'h0);
      chk_byte("status", 8'h1f, status);
      exec(OP_ADDWF, `SFR_A_STATUS, 1'b1, 3'h0);
      chk_byte("status", 8'h3a, status);
      exec(OP_CLRF, `SFR_A_STATUS, 1'b1, 3'h0);
      chk_byte("status", 8'h04, status);
      exec(OP_ADDWF, `SFR_A_STATUS, 1'b0, 3'h0);
      chk_byte("w", 8'h23, w);
      chk_byte("status", 8'h02, status);
      rd(`SFR_A_STATUS, v);
      chk_byte("status rd", 8'h02, v);
   endtask : t_status

   task automatic t_pindir();
      wr(`SFR_A_PINDIR, 8'h00);
      rd(`SFR_A_PINDIR, v);
      chk_byte("dir", 8'h08, v);
      chk_byte("oe_n", 8'h08, port_oe_n);
      exec(OP_BCF, `SFR_A_PINDIR, 1'b1, 3'h3);
      rd(`SFR_A_PINDIR, v);
      chk_byte("dir", 8'h08, v);
      exec(OP_BSF, `SFR_A_PINDIR, 1'b1, 3'h0);
      rd(`SFR_A_PINDIR, v);
      chk_byte("dir", 8'h09, v);
      exec(OP_COMF, `SFR_A_PINDIR, 1'b1, 3'h0);
      rd(`SFR_A_PINDIR, v);
      chk_byte("dir", 8'hfe, v);
   endtask : t_pindir

   task automatic t_pcl();
      logic [7:0] e;
      e = pc_m[7:0];
      exec(OP_MOVF, `SFR_A_PCL, 1'b0, 3'h0);
      chk_byte("w", e, w);
      chk_pc(pc_m);
      wr(`SFR_A_HOLD, 8'hf5);
      wr(7'h21, 8'h40);
      exec(OP_MOVF, 7'h21, 1'b0, 3'h0);
      exec(OP_MOVWF, `SFR_A_PCL, 1'b1, 3'h0);
      pc_m = 13'h1540;
      chk_pc(pc_m);
      rd(`SFR_A_HOLD, v);
      chk_byte("hold", 8'hf5, v);
      wr(`SFR_A_HOLD, 8'h03);
      exec(OP_INCF, `SFR_A_PCL, 1'b1, 3'h0);
      pc_m = 13'h0341;
      chk_pc(pc_m);
      exec(OP_INCF, `SFR_A_PCL, 1'b0, 3'h0);
      chk_byte("w", 8'h42, w);
      chk_pc(pc_m);
      wr(`SFR_A_PCL, 8'h10);
      chk_pc(pc_m);
      wr(`SFR_A_HOLD, 8'h1f);
      exec(OP_MOVF, 7'h21, 1'b0, 3'h0);
      chk_pc(pc_m);
      rd(`SFR_A_PCL, v);
      chk_byte("pcl rd", pc_m[7:0], v);
   endtask : t_pcl

   task automatic t_bitops();
      wr(`SFR_GP_BASE, 8'h5a);
      exec(OP_BSF, `SFR_GP_BASE, 1'b1, 3'h0);
      rd(`SFR_GP_BASE, v);
      chk_byte("ram", 8'h5b, v);
      exec(OP_BCF, `SFR_GP_BASE, 1'b1, 3'h6);
      rd(`SFR_GP_BASE, v);
      chk_byte("ram", 8'h1b, v);
      wr(`SFR_A_PORT, 8'ha5);
      chk_byte("port", 8'ha5, port_out);
      rd(`SFR_A_PORT, v);
      chk_byte("pins", 8'h3c, v);
      exec(OP_BSF, `SFR_A_PORT, 1'b1, 3'h7);
      chk_byte("port", 8'hbc, port_out);
      rd(7'h7f, v);
      chk_byte("unmapped", 8'h00, v);
   endtask : t_bitops

   // status written and read back to back, then the remaining operations
   task automatic t_alu();
      @(posedge clk_i);
      reg_we <= 1'b1;
      reg_addr <= `SFR_A_STATUS;
      reg_wdata <= 8'h12;
      @(posedge clk_i);
      reg_we <= 1'b0;
      reg_re <= 1'b1;
      @(posedge clk_i);
      reg_re <= 1'b0;
      #1;
      chk_byte("status rd", 8'h12, reg_rdata);
      wr(7'h22, 8'h0f);
      exec(OP_CLRW, 7'h22, 1'b1, 3'h0);
      chk_byte("w", 8'h00, w);
      chk_byte("status", 8'h16, status);
      exec(OP_IORWF, 7'h22, 1'b0, 3'h0);
      chk_byte("w", 8'h0f, w);
      chk_byte("status", 8'h12, status);
      exec(OP_SUBWF, 7'h22, 1'b1, 3'h0);
      chk_byte("status", 8'h17, status);
      exec(OP_DECF, 7'h22, 1'b1, 3'h0);
      chk_byte("status", 8'h13, status);
      exec(OP_XORWF, 7'h22, 1'b1, 3'h0);
      exec(OP_RRF, 7'h22, 1'b0, 3'h0);
      chk_byte("w", 8'hf8, w);
      chk_byte("status", 8'h12, status);
      exec(OP_SWAPF, 7'h22, 1'b0, 3'h0);
      chk_byte("w", 8'h0f, w);
      exec(OP_ANDWF, 7'h22, 1'b0, 3'h0);
      chk_byte("status", 8'h16, status);
      exec(OP_RLF, 7'h22, 1'b1, 3'h0);
      chk_byte("status", 8'h17, status);
      rd(7'h22, v);
      chk_byte("ram", 8'he0, v);
   endtask : t_alu

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      t_reset();
      t_status();
      t_pindir();
      t_pcl();
      t_bitops();
      t_alu();
      finish_test();
   end
endmodule : sfr_operand_side_effects_test
